// [src/acs_seq.sv]
// serial control, channel sequencer and result framing of the converter
// assumes: CS_N, SCLK, DIN come from the host; ADC_CODE from the core
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - coding bit picks binary or twos complement
// - word: two zeros, channel, twelve result bits
// - range bit picks one or two references
// - address bits pick channel outside sequencing
// - sequence bits 11 run ascending channels
// - sequence starts at zero, steps by one
// - after final channel wrap to zero
// - write of 00 or 01 ends sequence, 11 restarts it
// - power bits set the power mode
// - power codes normal, shutdown, auto; no 00
// - sequence off uses last written address
// - twelve bits load only with write set
// - conversion starts at select fall, sixteen clocks
module acs_seq (
  // clock and reset
  input  wire  logic                         CLOCK,
  input  wire  logic                         RST_N,
  // serial link from the host
  input  wire  logic                         CS_N,
  input  wire  logic                         SCLK,
  input  wire  logic                         DIN,
  output logic                               DOUT_O,
  output logic                               DOUT_OE,
  // converter core
  input  wire  logic [acs_pkg::CODE_BITS-1:0] ADC_CODE,
  output logic [1:0]                         CH_SEL,
  output logic                               SPAN_DOUBLE,
  output logic                               POWER_DOWN,
  // register bus
  input  wire  logic [acs_pkg::AXI_AW-1:0]   S_AXI_AWADDR,
  input  wire  logic                         S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire  logic [31:0]                  S_AXI_WDATA,
  input  wire  logic [3:0]                   S_AXI_WSTRB,
  input  wire  logic                         S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire  logic                         S_AXI_BREADY,
  input  wire  logic [acs_pkg::AXI_AW-1:0]   S_AXI_ARADDR,
  input  wire  logic                         S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire  logic                         S_AXI_RREADY
);
  import acs_pkg::*;

  logic [2:0]           cs_sync_q;     // select synchroniser and history
  logic [2:0]           sck_sync_q;    // clock synchroniser and history
  logic [1:0]           din_sync_q;    // data synchroniser
  logic                 cs_fall;       // start of a transfer
  logic                 cs_rise;       // end of a transfer
  logic                 sck_fall;      // serial clock falling edge
  acs_link_t            link_q;        // link state
  logic [4:0]           cnt_q;         // falling edges seen this transfer
  logic [CTRL_BITS-1:0] din_sr_q;      // received control bits
  logic [WORD_BITS-1:0] out_sr_q;      // result word being sent
  logic [WORD_BITS-1:0] word_q;        // last framed word
  logic                 wake_q;        // transfer began in full shutdown
  acs_ctrl_t            ctrl_q;        // control register
  acs_ctrl_t            new_ctrl;      // control word just received
  logic                 ctrl_we;       // control register load
  logic                 seq_on_q;      // sequence running
  logic [1:0]           seq_ch_q;      // next sequence channel
  logic [1:0]           seq_last_q;    // final sequence channel
  logic [1:0]           conv_ch_q;     // channel of this conversion
  logic                 asleep_q;      // auto shutdown between transfers
  logic                 lock_q;        // software blocks link writes
  logic [1:0]           ch_now;        // channel for the next conversion
  logic [CODE_BITS-1:0] coded;         // result in chosen coding

  // two flip-flops on every pin, third stage only for edge finding
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cs_sync_q  <= 3'h7;
      sck_sync_q <= 3'h7;
      din_sync_q <= 2'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], CS_N};
      sck_sync_q <= {sck_sync_q[1:0], SCLK};
      din_sync_q <= {din_sync_q[0], DIN};
    end
  end

  assign cs_fall  = cs_sync_q[2] & ~cs_sync_q[1];
  assign cs_rise  = ~cs_sync_q[2] & cs_sync_q[1];
  assign sck_fall = sck_sync_q[2] & ~sck_sync_q[1] & (link_q == LK_XFER);

  // link state follows the select line
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      link_q <= LK_IDLE;
    end else begin
      unique case (link_q)
        LK_IDLE: if (cs_fall) link_q <= LK_XFER;
        LK_XFER: if (cs_rise) link_q <= LK_IDLE;
      endcase
    end
  end

  // count falling clock edges, stop at a full transfer
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 5'h0;
    end else if (cs_fall) begin
      cnt_q <= 5'h0;
    end else if (sck_fall && cnt_q < XFER_CLKS) begin
      cnt_q <= cnt_q + 5'h1;
    end
  end

  // only the first twelve data bits are kept
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      din_sr_q <= '0;
    end else if (sck_fall && cnt_q < LOAD_CLKS) begin
      din_sr_q <= {din_sr_q[CTRL_BITS-2:0], din_sync_q[1]};
    end
  end

  // channel for the conversion about to start
  assign ch_now = seq_on_q ? seq_ch_q : ctrl_q.chan;
  // twos complement flips the top bit of the straight code
  assign coded  = ctrl_q.coding ? ADC_CODE
                : {~ADC_CODE[CODE_BITS-1], ADC_CODE[CODE_BITS-2:0]};

  // frame the word at select fall, shift on each of the first sixteen falling edges
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      out_sr_q  <= '0;
      word_q    <= '0;
      conv_ch_q <= 2'h0;
      wake_q    <= 1'b0;
    end else if (cs_fall) begin
      out_sr_q  <= {LEAD_ZERO, ch_now, coded};
      word_q    <= {LEAD_ZERO, ch_now, coded};
      conv_ch_q <= ch_now;
      wake_q    <= (ctrl_q.pm == PM_FULL);
    end else if (sck_fall && cnt_q < XFER_CLKS) begin
      out_sr_q  <= {out_sr_q[WORD_BITS-2:0], 1'b0};
    end
  end

  assign DOUT_O  = out_sr_q[WORD_BITS-1];
  // output is not driven in the wake-up transfer from full shutdown
  assign DOUT_OE = (link_q == LK_XFER) & ~wake_q;

  // load after a full transfer when the write bit is set and the link is not locked
  assign new_ctrl = acs_parse(din_sr_q);
  assign ctrl_we  = cs_rise && (link_q == LK_XFER) && cnt_q == XFER_CLKS
                    && din_sr_q[CB_WRITE] && !lock_q;

  // control register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_we) begin
      ctrl_q <= new_ctrl;
    end
  end

  // sequencer: start, step, wrap and end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      seq_on_q   <= 1'b0;
      seq_ch_q   <= 2'h0;
      seq_last_q <= 2'h0;
    end else if (ctrl_we) begin
      if ({new_ctrl.seq_hi, new_ctrl.seq_lo} == SEQ_RUN) begin
        seq_on_q   <= 1'b1;
        seq_ch_q   <= 2'h0;
        seq_last_q <= new_ctrl.chan;
      end else if ({new_ctrl.seq_hi, new_ctrl.seq_lo} != SEQ_KEEP) begin
        seq_on_q   <= 1'b0;
      end
    end else if (cs_fall && seq_on_q) begin
      if (seq_ch_q == seq_last_q) begin
        seq_ch_q <= 2'h0;
      end else begin
        seq_ch_q <= seq_ch_q + 2'h1;
      end
    end
  end

  // auto shutdown sleeps from transfer end to next select fall
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      asleep_q <= 1'b0;
    end else if (cs_fall) begin
      asleep_q <= 1'b0;
    end else if (cs_rise) begin
      asleep_q <= ((ctrl_we ? new_ctrl.pm : ctrl_q.pm) == PM_AUTO);
    end
  end

  // core controls, registered; code 00 is treated as normal
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CH_SEL      <= 2'h0;
      SPAN_DOUBLE <= 1'b1;
      POWER_DOWN  <= 1'b0;
    end else begin
      CH_SEL      <= ch_now;
      SPAN_DOUBLE <= ~ctrl_q.range;
      POWER_DOWN  <= (ctrl_q.pm == PM_FULL) | asleep_q;
    end
  end

  // register bus slave
  logic             aw_hold_q;   // write address held
  logic             w_hold_q;    // write data held
  logic [AXI_AW-1:0] awaddr_q;   // held write address
  logic [31:0]      wdata_q;     // held write data
  logic [3:0]       wstrb_q;     // held byte enables
  logic             rd_hit;      // read address mapped

  assign S_AXI_AWREADY = ~aw_hold_q;
  assign S_AXI_WREADY  = ~w_hold_q;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // accept address and data in either order, answer when both held
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
      lock_q       <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (aw_hold_q && w_hold_q && !S_AXI_BVALID) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (awaddr_q[AXI_AW-1:2] > REG_CFG[AXI_AW-1:2])
                        ? RESP_SERR : RESP_OKAY;
        // only the lock bit is writable
        if (awaddr_q[AXI_AW-1:2] == REG_CFG[AXI_AW-1:2] && wstrb_q[0]) begin
          lock_q <= wdata_q[0];
        end
      end
    end
  end

  assign rd_hit = 1'b1;  // every word of the small map is decoded

  // reads answer on the same edge that takes the address
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= rd_hit;
      S_AXI_RRESP  <= RESP_OKAY;
      unique case ({S_AXI_ARADDR[AXI_AW-1:2], 2'h0})
        REG_CTRL: S_AXI_RDATA <= {24'h0, ctrl_q};
        REG_STAT: S_AXI_RDATA <= {24'h0, link_q, POWER_DOWN, seq_on_q,
                                  seq_last_q, seq_ch_q};
        REG_WORD: S_AXI_RDATA <= {16'h0, word_q};
        REG_CFG:  S_AXI_RDATA <= {31'h0, lock_q};
        default:  S_AXI_RDATA <= 32'h0;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_word_frame: assert property (cs_fall |=>
    out_sr_q[WORD_BITS-1 -: 2] == LEAD_ZERO
    && out_sr_q[WORD_BITS-3 -: 2] == $past(ch_now))
    else $error("result word frame wrong");
  a_twos_code: assert property (cs_fall && !ctrl_q.coding |=>
    out_sr_q[CODE_BITS-1] != $past(ADC_CODE[CODE_BITS-1]))
    else $error("twos complement top bit wrong");
  a_fixed_chan: assert property (cs_fall && !seq_on_q |=>
    conv_ch_q == $past(ctrl_q.chan))
    else $error("fixed channel not from address bits");
  a_seq_start: assert property (ctrl_we && new_ctrl.seq_hi &&
    new_ctrl.seq_lo |=> seq_on_q && seq_ch_q == 2'h0)
    else $error("sequence did not start at zero");
  a_seq_step: assert property (cs_fall && seq_on_q &&
    seq_ch_q != seq_last_q |=> seq_ch_q == $past(seq_ch_q) + 2'h1)
    else $error("sequence did not step by one");
  a_seq_wrap: assert property (cs_fall && seq_on_q &&
    seq_ch_q == seq_last_q |=> seq_ch_q == 2'h0 && seq_on_q)
    else $error("sequence did not wrap");
  a_seq_end: assert property (ctrl_we && !new_ctrl.seq_hi |=>
    !seq_on_q)
    else $error("sequence not ended by write");
  a_no_write: assert property (cs_rise && !din_sr_q[CB_WRITE] |=>
    $stable(ctrl_q))
    else $error("control changed without write bit");
  a_full_off: assert property (ctrl_q.pm == PM_FULL ##1
    ctrl_q.pm == PM_FULL |-> POWER_DOWN)
    else $error("full shutdown not signalled");
  a_shift_cnt: assert property (sck_fall && cnt_q == XFER_CLKS |=>
    $stable(out_sr_q))
    else $error("shifted beyond sixteen clocks");

  c_seq_wrap: cover property (cs_fall && seq_on_q && seq_ch_q == seq_last_q
    && seq_last_q != 2'h0);
  c_keep_write: cover property (ctrl_we && seq_on_q && new_ctrl.seq_hi
    && !new_ctrl.seq_lo);
  c_wake_xfer: cover property (cs_fall && ctrl_q.pm == PM_FULL);
endmodule : acs_seq

// [src/acs_pkg.sv]
// constants, control fields and types of the converter channel sequencer
// assumes: shared by the sequencer core and the bench; no clock of its own
package acs_pkg;
  // serial transfer shape
  localparam int unsigned CTRL_BITS = 12;       // control bits per transfer
  localparam int unsigned WORD_BITS = 16;       // bits of one result word
  localparam int unsigned CODE_BITS = 12;       // converter result width
  localparam logic [4:0]  XFER_CLKS = 5'h10;    // clocks of a full transfer
  localparam logic [4:0]  LOAD_CLKS = 5'h0C;    // clocks that carry control

  // control word field positions, first bit received is bit 11
  localparam int unsigned CB_WRITE  = 11;
  localparam int unsigned CB_SEQ_HI = 10;
  localparam int unsigned CB_CH_HI  = 7;
  localparam int unsigned CB_CH_LO  = 6;
  localparam int unsigned CB_PM_HI  = 5;
  localparam int unsigned CB_PM_LO  = 4;
  localparam int unsigned CB_SEQ_LO = 3;
  localparam int unsigned CB_RANGE  = 1;
  localparam int unsigned CB_CODING = 0;

  // encodings
  localparam logic [1:0] PM_NORMAL = 2'h3;      // full power
  localparam logic [1:0] PM_FULL   = 2'h2;      // full shutdown
  localparam logic [1:0] PM_AUTO   = 2'h1;      // shutdown after conversion
  localparam logic [1:0] SEQ_KEEP  = 2'h2;      // write without ending run
  localparam logic [1:0] SEQ_RUN   = 2'h3;      // start ascending sequence
  localparam logic [1:0] LEAD_ZERO = 2'h0;      // leading bits of a word

  // register map, byte addresses
  localparam int unsigned AXI_AW   = 4;
  localparam logic [3:0] REG_CTRL  = 4'h0;      // control readback
  localparam logic [3:0] REG_STAT  = 4'h4;      // sequencer state
  localparam logic [3:0] REG_WORD  = 4'h8;      // last output word
  localparam logic [3:0] REG_CFG   = 4'hC;      // link write lock
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SERR = 2'h2;

  // decoded control register
  typedef struct packed {
    logic       seq_hi;                         // sequence_ctl_hi
    logic [1:0] chan;                           // channel_addr_hi/lo
    logic [1:0] pm;                             // power_mode_hi/lo
    logic       seq_lo;                         // sequence_ctl_lo
    logic       range;                          // 1: span of one reference
    logic       coding;                         // 1: straight binary
  } acs_ctrl_t;

  localparam acs_ctrl_t CTRL_RST = '{seq_hi: 1'b0, chan: 2'h0,
    pm: PM_NORMAL, seq_lo: 1'b0, range: 1'b0, coding: 1'b0};

  // link state, one-hot
  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_XFER = 2'b10
  } acs_link_t;

  // pick the fields out of a received control word
  function automatic acs_ctrl_t acs_parse(input logic [CTRL_BITS-1:0] w);
    acs_ctrl_t c;
    c.seq_hi = w[CB_SEQ_HI];
    c.chan   = {w[CB_CH_HI], w[CB_CH_LO]};
    c.pm     = {w[CB_PM_HI], w[CB_PM_LO]};
    c.seq_lo = w[CB_SEQ_LO];
    c.range  = w[CB_RANGE];
    c.coding = w[CB_CODING];
    return c;
  endfunction : acs_parse
endpackage : acs_pkg

// [testbench/acs_host_model.sv]
// host side of the serial link: frames transfers on select, clock and data
// assumes: the bench resolves the data-out line before it reaches this model
`timescale 1ns/1ps
module acs_host_model (
  // serial link toward the device
  output logic cs_n,
  output logic sclk,
  output logic din,
  input  wire  logic dout
);
  // link idles deselected with the clock parked high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // one frame: n clock falls, data changed while the clock is high
  task automatic xfer(input logic [15:0] w, input int n, input int half,
                      output logic [15:0] rd);
    int k;
    rd   = '0;
    #1.25;                                      // keep pin changes off edges
    din  = w[15];
    #(half);
    cs_n = 1'b0;
    #(half);
    for (k = 0; k < n; k++) begin
      rd   = {rd[14:0], dout};                  // bit is settled before fall
      sclk = 1'b0;
      #(half);
      sclk = 1'b1;
      din  = (k < 15) ? w[14-k] : ~din;         // no stale level after frame
      #(half);
    end
    cs_n = 1'b1;
    #(4*half);                                  // quiet time before next frame
  endtask : xfer
endmodule : acs_host_model

// [testbench/tb_top.sv]
// self-checking bench of the sequencer: serial host model plus AXI master
// assumes: control is loaded at select rise and used by the next transfer
`timescale 1ns/1ps
module tb_top;
  import acs_pkg::*;
  logic                 CLOCK, RST_N, DOUT_O, DOUT_OE, SPAN_DOUBLE, POWER_DOWN;
  wire                  CS_N, SCLK, DIN, dout_w;
  logic [1:0]           CH_SEL, S_AXI_BRESP, S_AXI_RRESP;
  logic [CODE_BITS-1:0] ADC_CODE;
  logic [AXI_AW-1:0]    S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]          S_AXI_WDATA, S_AXI_RDATA, rv;
  logic [3:0]           S_AXI_WSTRB;
  logic                 S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic                 S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic                 S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic                 S_AXI_RREADY, park_q, oe_seen;
  logic [1:0]           rsp;
  logic [15:0]          rd;
  int                   fail_count, n_tests, i;

  acs_seq u_acs_seq (.CLOCK, .RST_N, .CS_N, .SCLK, .DIN, .DOUT_O, .DOUT_OE,
    .ADC_CODE, .CH_SEL, .SPAN_DOUBLE, .POWER_DOWN, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  acs_host_model u_acs_host_model (.cs_n(CS_N), .sclk(SCLK), .din(DIN),
    .dout(dout_w));

  // undriven data-out shows a toggling pattern, never the last bit
  assign dout_w = DOUT_OE ? DOUT_O : park_q;
  always @(posedge CLOCK) park_q <= ~park_q;
  // notes whether the device drove data-out during the frame
  always @(posedge CLOCK) if (!CS_N && DOUT_OE) oe_seen <= 1'b1;

  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      fail_count++;
    end
  endtask : chk

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a; S_AXI_AWVALID <= 1'b1; S_AXI_WDATA <= d;
    S_AXI_WVALID <= 1'b1; S_AXI_BREADY <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLOCK);
      if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) break;
    end
    S_AXI_BREADY <= 1'b0;
    chk(S_AXI_BRESP, RESP_OKAY, "write response");
    if (k == 50) begin
      chk(0, 1, "write timeout");
      tally_and_finish();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int k;
    @(posedge CLOCK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1'b1; S_AXI_RREADY <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLOCK);
      if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    d = S_AXI_RDATA;
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RRESP, RESP_OKAY, "read response");
    if (k == 50) begin
      chk(0, 1, "read timeout");
      tally_and_finish();
    end
  endtask : axi_rd

  function automatic logic [11:0] ctl(logic wr, logic sh, logic [1:0] ch,
      logic [1:0] pm, logic sl, logic rg, logic cd);
    return {wr, sh, 2'b00, ch, pm, sl, 1'b0, rg, cd};
  endfunction : ctl

  function automatic logic [15:0] wexp(logic [1:0] ch, logic [11:0] c,
                                       logic cd);
    return {LEAD_ZERO, ch, cd ? c : {~c[11], c[10:0]}};
  endfunction : wexp

  // one full frame with a fresh converter code
  task automatic run(input logic [11:0] c, input logic [11:0] code,
                     input int half);
    @(posedge CLOCK);
    ADC_CODE <= code;
    oe_seen = 1'b0;
    u_acs_host_model.xfer({c, 4'h0}, 16, half, rd);
  endtask : run

  task automatic t_reset();
    chk({CH_SEL, SPAN_DOUBLE, POWER_DOWN}, 4'h2, "reset outputs");
    axi_rd(REG_CTRL, rv);
    chk(rv, 32'h18, "control reset");
    axi_wr(REG_CTRL, 32'hFF);
    axi_rd(REG_CTRL, rv);
    chk(rv, 32'h18, "control read-only");
    axi_rd(REG_STAT, rv);
    chk(rv, 32'h40, "status idle");
    run(ctl(1, 0, 0, PM_NORMAL, 0, 0, 0), 12'h123, 32);
  endtask : t_reset

  task automatic t_manual();
    for (i = 0; i < 4; i++) begin
      run(ctl(1, 0, i, PM_NORMAL, 0, i[0], i[1]), 12'h000, 32);
      chk(CH_SEL, i[1:0], "channel routed");
      chk(SPAN_DOUBLE, !i[0], "span");
      run(ctl(0, 0, 0, 0, 0, 0, 0), 12'h8A5 + i, 32);
      chk(rd, wexp(i, 12'h8A5 + i, i[1]), "manual word");
      chk(oe_seen, 1'b1, "data-out driven");
      axi_rd(REG_WORD, rv);
      chk(rv, wexp(i, 12'h8A5 + i, i[1]), "word register");
    end
  endtask : t_manual

  task automatic t_seq();
    run(ctl(1, 1, 2, PM_NORMAL, 1, 0, 1), 12'h001, 32);
    for (i = 0; i < 5; i++) begin
      run(ctl(0, 1, 3, PM_NORMAL, 1, 0, 0), 12'h3C0 + i, 32);
      chk(rd, wexp(i % 3, 12'h3C0 + i, 1), "sequence step");
    end
    run(ctl(1, 1, 3, PM_NORMAL, 0, 0, 0), 12'hF0F, 32);
    chk(rd, wexp(2, 12'hF0F, 1), "keep write word");
    run(ctl(0, 0, 0, 0, 0, 0, 0), 12'h0F0, 32);
    chk(rd, wexp(0, 12'h0F0, 0), "sequence kept");
    run(ctl(1, 0, 1, PM_NORMAL, 0, 0, 1), 12'h555, 32);
    for (i = 0; i < 2; i++) begin
      run(ctl(0, 0, 0, 0, 0, 0, 0), 12'hAAA, 32);
      chk(rd, wexp(1, 12'hAAA, 1), "sequence ended");
    end
  endtask : t_seq

  task automatic t_refuse();
    @(posedge CLOCK);
    u_acs_host_model.xfer({ctl(1, 0, 3, PM_NORMAL, 0, 1, 1), 4'h0}, 12, 32, rd);
    chk(CH_SEL, 2'h1, "short frame ignored");
    run(ctl(0, 0, 3, PM_FULL, 0, 1, 0), 12'h777, 32);
    chk({CH_SEL, POWER_DOWN}, 3'h2, "write bit clear");
    axi_wr(REG_CFG, 32'h1);
    axi_rd(REG_CFG, rv);
    chk(rv[0], 1'b1, "lock set");
    run(ctl(1, 0, 2, PM_NORMAL, 0, 0, 1), 12'h777, 32);
    chk(CH_SEL, 2'h1, "locked link write");
    // a seventeenth clock fall must not shift the word again
    @(posedge CLOCK);
    ADC_CODE <= 12'h4B6;
    u_acs_host_model.xfer(16'h0, 17, 32, rd);
    chk(rd, 16'(wexp(2'h1, 12'h4B6, 1'b1) << 1), "no extra shift");
    axi_wr(REG_CFG, 32'h0);
    // a write with no byte enabled leaves the lock clear
    S_AXI_WSTRB <= 4'h0;
    axi_wr(REG_CFG, 32'h1);
    axi_rd(REG_CFG, rv);
    chk(rv[0], 1'b0, "strobe off keeps lock clear");
    S_AXI_WSTRB <= 4'hF;
  endtask : t_refuse

  task automatic t_power();
    run(ctl(1, 0, 1, PM_FULL, 0, 0, 1), 12'h100, 32);
    chk(POWER_DOWN, 1'b1, "full shutdown");
    run(ctl(1, 0, 1, PM_NORMAL, 0, 0, 1), 12'h100, 32);
    chk({oe_seen, POWER_DOWN}, 2'h0, "wake frame undriven");
    run(ctl(1, 0, 1, PM_AUTO, 0, 0, 1), 12'h200, 32);
    chk(POWER_DOWN, 1'b1, "auto shutdown");
    run(ctl(0, 0, 0, 0, 0, 0, 0), 12'h200, 32);
    chk({oe_seen, POWER_DOWN}, 2'h3, "auto frame then sleep");
    run(ctl(1, 0, 1, PM_NORMAL, 0, 0, 1), 12'h300, 32);
    chk(POWER_DOWN, 1'b0, "back to normal");
  endtask : t_power

  initial begin
    fail_count = 0; n_tests = 0; park_q = 1'b0; oe_seen = 1'b0;
    RST_N = 1'b0; ADC_CODE = '0; S_AXI_AWADDR = '0; S_AXI_AWVALID = 1'b0;
    S_AXI_WDATA = '0; S_AXI_WSTRB = 4'hF; S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0; S_AXI_ARADDR = '0; S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    t_reset();
    t_manual();
    t_seq();
    t_refuse();
    t_power();
    tally_and_finish();
  end
endmodule : tb_top
